// ### design/fan_pwm_pkg.sv
// Purpose: shared constants for the fan pwm and spin-up block
// Assumes: 125 MHz system clock
// Notes: register offsets are the device's byte addresses
package fan_pwm_pkg;
  localparam int CLK_HZ          = 125_000_000;
  // master pwm clock rates
  localparam int MCLK_FAST_HZ    = 360_000;
  localparam int MCLK_SLOW_HZ    = 1_400;
  localparam int FAST_DIV_CYC    = CLK_HZ / MCLK_FAST_HZ;
  localparam int SLOW_DIV_CYC    = CLK_HZ / MCLK_SLOW_HZ;
  // shortest spin-up time, doubled per code step
  localparam int SPINUP_BASE_US  = 50_000;
  localparam int SPINUP_BASE_CYC = (CLK_HZ / 1_000_000) * SPINUP_BASE_US;

  // register offsets
  localparam logic [7:0] ADDR_PWM_CFG  = 8'h4A;
  localparam logic [7:0] ADDR_SPIN_CFG = 8'h4B;
  localparam logic [7:0] ADDR_DUTY     = 8'h4C;
  localparam logic [7:0] ADDR_FREQ     = 8'h4D;

  // values after reset
  localparam logic [7:0] RST_PWM_CFG   = 8'h20;
  localparam logic [7:0] RST_SPIN_CFG  = 8'h3F;
  localparam logic [5:0] RST_DUTY      = 6'h00;
  localparam logic [4:0] RST_FREQ      = 5'h17;

  // field positions
  localparam int CFG_PROG_BIT   = 5;
  localparam int CFG_POL_BIT    = 4;
  localparam int CFG_SLOW_BIT   = 3;
  localparam int SPIN_FAST_BIT  = 5;
  localparam int SPIN_DUTY_LSB  = 3;
  localparam int SPIN_TIME_LSB  = 0;

  // spin-up duty levels in 64ths
  localparam logic [5:0] DUTY_HALF = 6'h20;
  localparam logic [5:0] DUTY_3Q   = 6'h30;
  localparam logic [5:0] DUTY_FULL = 6'h3F;

  typedef enum logic {SPIN_IDLE, SPIN_RUN} spin_state_t;
endpackage

// ### design/lut_select.sv
// Purpose: pick lookup table duty from remote temperature
// Assumes: entries in ascending temperature order
// Notes: highest exceeded entry wins, none gives zero duty
`timescale 1ns/1ns
module lut_select
  import fan_pwm_pkg::*;
#(
  parameter int ENTRIES = 8
) (
  // temperature in
  input  wire logic [6:0]           remote_temp,
  // table contents
  input  wire logic [ENTRIES*7-1:0] lut_temp,
  input  wire logic [ENTRIES*6-1:0] lut_pwm,
  // selected duty
  output wire logic [5:0]           lut_duty
);
  if (ENTRIES < 1) $error("lut_select needs at least one entry");

  wire logic [5:0] chain [0:ENTRIES];
  assign chain[0] = 6'h00;

  genvar i;
  for (i = 0; i < ENTRIES; i++) begin : g_entry
    assign chain[i+1] = (remote_temp > lut_temp[i*7 +: 7]) ? lut_pwm[i*6 +: 6] : chain[i];
  end

  assign lut_duty = chain[ENTRIES];
endmodule

// ### design/pwm_gen.sv
// Purpose: open-drain pwm waveform from duty and divider
// Assumes: duty in 64ths, 63 means always on
// Notes: period is twice the divider in master clock ticks
`timescale 1ns/1ns
module pwm_gen
  import fan_pwm_pkg::*;
#(
  parameter int FAST_DIV = FAST_DIV_CYC,
  parameter int SLOW_DIV = SLOW_DIV_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // control
  input  wire logic       slow_sel,
  input  wire logic       invert,
  input  wire logic [4:0] freq_n,
  input  wire logic [5:0] duty,
  // pin enable, low pulls the pin down
  output logic            pwm_oe_n
);
  if (FAST_DIV < 1 || FAST_DIV > 131071 || SLOW_DIV < 1 || SLOW_DIV > 131071)
    $error("pwm_gen divider out of range");

  logic [16:0] tick_cnt_r;
  logic [5:0]  phase_r;
  wire  [16:0] tick_last = slow_sel ? 17'(SLOW_DIV - 1) : 17'(FAST_DIV - 1);
  wire  [4:0]  n_eff     = (freq_n == 5'h00) ? 5'h01 : freq_n;
  wire  [5:0]  period    = {n_eff, 1'b0};
  wire         tick      = (tick_cnt_r >= tick_last);
  wire  [11:0] on_ticks  = 12'(({6'h00, duty} * {6'h00, period}) >> 6);
  wire         fan_on    = (duty == DUTY_FULL) || ({6'h00, phase_r} < on_ticks);
  wire         drive_low = invert ? fan_on : ~fan_on;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 17'h00000;
      phase_r    <= 6'h00;
      pwm_oe_n   <= 1'b1;
    end else begin
      tick_cnt_r <= tick ? 17'h00000 : tick_cnt_r + 17'h00001;
      if (tick) begin
        phase_r <= (phase_r >= period - 6'h01) ? 6'h00 : phase_r + 6'h01;
      end
      pwm_oe_n <= ~drive_low;
    end
  end

  property p_phase_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
    (tick && phase_r == period - 6'h01) |=> (phase_r == 6'h00);
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("pwm phase did not wrap");

  property p_full_on;
    @(posedge clk_sys) disable iff (!rst_n)
    (duty == DUTY_FULL && !invert) |=> pwm_oe_n;
  endproperty
  a_full_on: assert property (p_full_on) else $error("full duty pin not released");
endmodule

// ### design/fan_pwm_spinup.sv
// Purpose: fan pwm output with spin-up control and its registers
// Assumes: byte register port fed by the serial management engine
// Notes: reads answer one cycle after the read strobe
//
// How it works
// - normal spin-up uses duty and time fields
// - fast spin-up full duty, ends on time/tach
// - fast bit forces full duty during spin-up
// - time code zero skips spin-up entirely
// - duty code zero skips unless fast
// - duty codes give half, three quarters, full
// - time codes double from 0.05 s
// - pwm period is twice divider ticks
// - divider zero behaves as one
// - unused upper bits read zero, except pwm config bits 7:6, which read back as written
// - duty register shows table value, read-only, while program bit is clear
// - program bit allows direct duty writes
// - duty register reads zero during spin-up
// - clock select picks 360 kHz or 1.4 kHz
// - program bit gates duty register writes
// - table entry exceeded selects its duty
`timescale 1ns/1ns
module fan_spinup_top
  import fan_pwm_pkg::*;
#(
  parameter int LUT_ENTRIES     = 8,
  parameter int SLOW_DIV        = SLOW_DIV_CYC,
  parameter int SPINUP_BASE     = SPINUP_BASE_CYC
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // register port
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  // temperature and lookup table
  input  wire logic [6:0]               remote_temp,
  input  wire logic [LUT_ENTRIES*7-1:0] lut_temp,
  input  wire logic [LUT_ENTRIES*6-1:0] lut_pwm,
  // tachometer measurement result
  input  wire logic                     tach_at_setpoint,
  // status toward neighbouring logic
  output logic                          spinup_active,
  output logic      [1:0]               tach_mode,
  output logic                          lut_write_en,
  // open-drain pwm pin
  output logic                          pwm_out,
  output logic                          pwm_oe_n
);
  if (SPINUP_BASE < 1 || SPINUP_BASE > (2147483647 / 64))
    $error("spin-up base out of range");

  // registers
  logic [7:0]  pwm_cfg_r;
  logic [5:0]  spin_cfg_r;
  logic [5:0]  duty_man_r;
  logic [4:0]  freq_r;
  logic        req_zero_r;
  logic [31:0] spin_cnt_r;
  spin_state_t state_r;
  spin_state_t state_nxt;

  // field decode
  wire       prog      = pwm_cfg_r[CFG_PROG_BIT];
  wire       fast      = spin_cfg_r[SPIN_FAST_BIT];
  wire [1:0] duty_code = spin_cfg_r[SPIN_DUTY_LSB +: 2];
  wire [2:0] time_code = spin_cfg_r[SPIN_TIME_LSB +: 3];

  // address decode
  wire sel_cfg  = (reg_addr == ADDR_PWM_CFG);
  wire sel_spin = (reg_addr == ADDR_SPIN_CFG);
  wire sel_duty = (reg_addr == ADDR_DUTY);
  wire sel_freq = (reg_addr == ADDR_FREQ);

  // requested duty
  wire [5:0] lut_duty;
  wire [5:0] duty_req  = prog ? duty_man_r : lut_duty;
  wire       req_nz    = (duty_req != 6'h00);

  lut_select #(
    .ENTRIES (LUT_ENTRIES)
  ) u_lut (
    .remote_temp (remote_temp),
    .lut_temp    (lut_temp),
    .lut_pwm     (lut_pwm),
    .lut_duty    (lut_duty)
  );

  // spin-up decision
  wire spin_allowed = (time_code != 3'h0) && (fast || duty_code != 2'h0);
  wire spin_start   = req_zero_r && req_nz && spin_allowed;
  wire [31:0] spin_len  = 32'(SPINUP_BASE) << (time_code - 3'h1);
  wire spin_timeout = (spin_cnt_r >= spin_len - 32'h1);
  wire spin_tach    = fast && tach_at_setpoint;
  wire spin_end     = spin_timeout || spin_tach || !req_nz;
  wire spinning     = (state_r == SPIN_RUN);

  // spin-up duty
  wire [5:0] code_duty = (duty_code == 2'h1) ? DUTY_HALF :
                         (duty_code == 2'h2) ? DUTY_3Q : DUTY_FULL;
  wire [5:0] spin_duty = fast ? DUTY_FULL : code_duty;
  wire [5:0] duty_out  = spinning ? spin_duty : duty_req;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SPIN_IDLE: begin
        if (spin_start) begin
          state_nxt = SPIN_RUN;
        end
      end
      SPIN_RUN: begin
        if (spin_end) begin
          state_nxt = SPIN_IDLE;
        end
      end
      default: state_nxt = SPIN_IDLE;
    endcase
  end

  // read data
  wire [5:0] duty_rd = spinning ? 6'h00 : duty_req;
  wire [7:0] rd_mux  = sel_cfg  ? pwm_cfg_r :
                       sel_spin ? {2'b00, spin_cfg_r} :
                       sel_duty ? {2'b00, duty_rd} :
                       sel_freq ? {3'b000, freq_r} : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cfg_r  <= RST_PWM_CFG;
      spin_cfg_r <= RST_SPIN_CFG[5:0];
      freq_r     <= RST_FREQ;
    end else if (reg_wr) begin
      if (sel_cfg) begin
        pwm_cfg_r <= reg_wdata & 8'hFB;
      end
      if (sel_spin) begin
        spin_cfg_r <= reg_wdata[5:0];
      end
      if (sel_freq) begin
        freq_r <= reg_wdata[4:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      duty_man_r <= RST_DUTY;
    end else if (reg_wr && sel_duty && prog) begin
      duty_man_r <= reg_wdata[5:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= SPIN_IDLE;
      spin_cnt_r <= 32'h00000000;
      req_zero_r <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      spin_cnt_r <= (state_nxt == SPIN_RUN && spinning) ? spin_cnt_r + 32'h1 : 32'h0;
      req_zero_r <= !req_nz;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata     <= 8'h00;
      spinup_active <= 1'b0;
      tach_mode     <= 2'b00;
      lut_write_en  <= 1'b0;
      pwm_out       <= 1'b0;
    end else begin
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
      spinup_active <= (state_nxt == SPIN_RUN);
      tach_mode     <= pwm_cfg_r[1:0];
      lut_write_en  <= prog;
      pwm_out       <= 1'b0;
    end
  end

  pwm_gen #(
    .FAST_DIV (FAST_DIV_CYC),
    .SLOW_DIV (SLOW_DIV)
  ) u_pwm (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .slow_sel (pwm_cfg_r[CFG_SLOW_BIT]),
    .invert   (pwm_cfg_r[CFG_POL_BIT]),
    .freq_n   (freq_r),
    .duty     (duty_out),
    .pwm_oe_n (pwm_oe_n)
  );

  // checks
  property p_read_zero_spin;
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && sel_duty && spinning) |=> (reg_rdata == 8'h00);
  endproperty
  a_read_zero_spin: assert property (p_read_zero_spin) else $error("duty read nonzero in spin");

  property p_no_spin_time0;
    @(posedge clk_sys) disable iff (!rst_n)
    (!spinning && time_code == 3'h0) |=> !spinning;
  endproperty
  a_no_spin_time0: assert property (p_no_spin_time0) else $error("spin-up with time code 0");

  property p_no_spin_duty0;
    @(posedge clk_sys) disable iff (!rst_n)
    (!spinning && duty_code == 2'h0 && !fast) |=> !spinning;
  endproperty
  a_no_spin_duty0: assert property (p_no_spin_duty0) else $error("spin-up with duty code 0");

  property p_fast_full;
    @(posedge clk_sys) disable iff (!rst_n)
    (spinning && fast) |-> (duty_out == DUTY_FULL);
  endproperty
  a_fast_full: assert property (p_fast_full) else $error("fast spin-up not full duty");

  property p_half_duty;
    @(posedge clk_sys) disable iff (!rst_n)
    (spinning && !fast && duty_code == 2'h1) |-> (duty_out == DUTY_HALF);
  endproperty
  a_half_duty: assert property (p_half_duty) else $error("duty code 1 not half");

  property p_tach_end;
    @(posedge clk_sys) disable iff (!rst_n)
    (spinning && fast && tach_at_setpoint) |=> !spinning ##1 !spinup_active;
  endproperty
  a_tach_end: assert property (p_tach_end) else $error("tach did not end spin-up");

  property p_start;
    @(posedge clk_sys) disable iff (!rst_n)
    (!spinning && spin_start) |=> spinning ##0 spinup_active;
  endproperty
  a_start: assert property (p_start) else $error("spin-up did not start");

  property p_freq_hi_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && sel_freq) |=> (reg_rdata[7:5] == 3'b000);
  endproperty
  a_freq_hi_zero: assert property (p_freq_hi_zero) else $error("freq upper bits nonzero");

  property p_man_write;
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && sel_duty) |=> (duty_man_r == ($past(prog) ? $past(reg_wdata[5:0]) : $past(duty_man_r)));
  endproperty
  a_man_write: assert property (p_man_write) else $error("duty write gating wrong");

  property p_lut_read;
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && sel_duty && !prog && !spinning) |=> (reg_rdata == {2'b00, $past(lut_duty)});
  endproperty
  a_lut_read: assert property (p_lut_read) else $error("duty read not table value");

  property p_time_end;
    @(posedge clk_sys) disable iff (!rst_n)
    (spinning && spin_timeout) |=> !spinning;
  endproperty
  a_time_end: assert property (p_time_end) else $error("spin-up outlived its time");

  c_spin_normal: cover property (@(posedge clk_sys) disable iff (!rst_n) spinning && !fast ##1 !spinning);
  c_spin_fast_tach: cover property (@(posedge clk_sys) disable iff (!rst_n) spinning && spin_tach);
  c_manual_write: cover property (@(posedge clk_sys) disable iff (!rst_n) reg_wr && sel_duty && prog);
endmodule

// ### verification/fan_model.sv
// Purpose: fan behind the open-drain pwm pin, with tach feedback
// Assumes: pin pulled up when released, normal polarity (open = fan on)
// Notes: speed builds while the pin is released and decays while it is pulled low
`timescale 1ns/1ns
module fan_model #(
  parameter int SPEED_CYC = 900
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // pin and tach
  input  wire logic pwm_oe_n,
  output logic      tach_at_setpoint
);
  int   speed;
  logic pin;

  // pull-up wins when the pin is released
  assign pin = pwm_oe_n ? 1'b1 : 1'b0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      speed <= 0;
      tach_at_setpoint <= 1'b0;
    end else begin
      if (pin && speed < SPEED_CYC)
        speed <= speed + 1;
      else if (!pin && speed > 0)
        speed <= speed - 1;
      tach_at_setpoint <= (speed >= SPEED_CYC);
    end
  end
endmodule

// ### verification/fan_pwm_spinup_control_tb.sv
// Purpose: self-checking bench for fan pwm and spin-up control
// Assumes: short spin-up base and slow divider for run time
// Notes: inputs change on the falling edge
`timescale 1ns/1ns
module fan_pwm_spinup_control_tb
  import fan_pwm_pkg::*;
;
  localparam int SB = 20;
  localparam int SD = 40;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [6:0]  remote_temp = 7'h00;
  logic [55:0] lut_temp = {{7{7'h7F}}, 7'h40};
  logic [47:0] lut_pwm = {{7{6'h3F}}, 6'h15};
  logic        tach_at_setpoint;
  logic        spinup_active;
  logic [1:0]  tach_mode;
  logic        lut_write_en;
  logic        pwm_out;
  logic        pwm_oe_n;
  int          n_fail = 0;
  int          checked = 0;

  always #4 clk_sys = ~clk_sys;

  fan_spinup_top #(.LUT_ENTRIES(8), .SLOW_DIV(SD), .SPINUP_BASE(SB)) i_fan_spinup_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .remote_temp(remote_temp),
    .lut_temp(lut_temp), .lut_pwm(lut_pwm), .tach_at_setpoint(tach_at_setpoint),
    .spinup_active(spinup_active), .tach_mode(tach_mode), .lut_write_en(lut_write_en),
    .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n));

  fan_model i_fan_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .pwm_oe_n(pwm_oe_n),
    .tach_at_setpoint(tach_at_setpoint));

  task end_sim;
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    chk($sformatf("rdata_%h", a), {8'h00, exp}, {8'h00, reg_rdata});
  endtask

  // longest released stretch of the pin over a fixed window
  task high_run(input int exp);
    int run;
    int best;
    run = 0;
    best = 0;
    repeat (1500) begin
      @(negedge clk_sys);
      run = (pwm_oe_n === 1'b1) ? run + 1 : 0;
      if (run > best)
        best = run;
    end
    chk("high_run", exp[15:0], best[15:0]);
  endtask

  // request 0 -> 0x10, then time the spin-up and count on cycles
  task run_spin(input logic [7:0] cfg, input int lo, input int hi, input int on);
    int len;
    int ont;
    len = 0;
    ont = 0;
    wr(ADDR_SPIN_CFG, cfg);
    wr(ADDR_DUTY, 8'h10);
    for (int i = 0; i < 3000 && spinup_active === 1'b1; i++) begin
      len++;
      if (len >= 10 && len < 650 && pwm_oe_n === 1'b1)
        ont++;
      reg_addr = ADDR_DUTY;
      reg_rd = (len == 2);
      if (len == 4) chk("duty_in_spin", 16'h0000, {8'h00, reg_rdata});
      @(negedge clk_sys);
    end
    if (len >= 3000)
      end_sim_timeout();
    chk("spin_len_ok", 16'h0001, {15'h0000, (len >= lo && len <= hi)});
    if (on >= 0) chk("spin_on", on[15:0], ont[15:0]);
    rd(ADDR_DUTY, 8'h10);
    wr(ADDR_DUTY, 8'h00);
    repeat (1000) @(negedge clk_sys);
  endtask

  task end_sim_timeout;
    n_fail++;
    $display("[ERR] spinup_active expected 0 seen 1");
    end_sim();
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    chk("pwm_oe_n_rst", 16'h0001, {15'h0000, pwm_oe_n});
    rst_n = 1'b1;
    @(negedge clk_sys);
    rd(ADDR_PWM_CFG, 8'h20);
    chk("pwm_out", 16'h0000, {15'h0000, pwm_out});
    rd(ADDR_SPIN_CFG, 8'h3F);
    rd(ADDR_FREQ, 8'h17);
    rd(ADDR_DUTY, 8'h00);
    rd(8'h30, 8'h00);
    wr(ADDR_FREQ, 8'hFF);
    rd(ADDR_FREQ, 8'h1F);
    wr(ADDR_SPIN_CFG, 8'hFF);
    rd(ADDR_SPIN_CFG, 8'h3F);
    wr(ADDR_SPIN_CFG, 8'h00);
    wr(ADDR_PWM_CFG, 8'h08);
    chk("lut_write_en", 16'h0000, {15'h0000, lut_write_en});
    wr(ADDR_DUTY, 8'h2A);
    rd(ADDR_DUTY, 8'h00);
    remote_temp = 7'h41;
    rd(ADDR_DUTY, 8'h15);
    remote_temp = 7'h40;
    rd(ADDR_DUTY, 8'h00);
    wr(ADDR_PWM_CFG, 8'h28);
    wr(ADDR_FREQ, 8'h08);
    wr(ADDR_DUTY, 8'h20);
    high_run(8 * SD);
    wr(ADDR_FREQ, 8'h00);
    high_run(SD);
    wr(ADDR_PWM_CFG, 8'h20);
    wr(ADDR_FREQ, 8'h01);
    high_run(FAST_DIV_CYC);
    // inverted polarity: pin released while fan is off
    wr(ADDR_PWM_CFG, 8'h3F);
    wr(ADDR_FREQ, 8'h08);
    wr(ADDR_DUTY, 8'h10);
    high_run(12 * SD);
    rd(ADDR_PWM_CFG, 8'h3B);
    chk("tach_mode", 16'h0003, {14'h0000, tach_mode});
    wr(ADDR_PWM_CFG, 8'h28);
    wr(ADDR_FREQ, 8'h08);
    wr(ADDR_DUTY, 8'h00);
    repeat (1000) @(negedge clk_sys);
    run_spin(8'h38, 0, 0, -1);
    run_spin(8'h07, 0, 0, -1);
    run_spin(8'h09, SB - 1, SB + 2, -1);
    run_spin(8'h0F, 64 * SB - 1, 64 * SB + 2, 320);
    run_spin(8'h17, 64 * SB - 1, 64 * SB + 2, 480);
    run_spin(8'h1F, 64 * SB - 1, 64 * SB + 2, 640);
    run_spin(8'h27, 880, 960, 640);
    // reset again in mid-run
    rst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("pwm_oe_n_rst", 16'h0001, {15'h0000, pwm_oe_n});
    rst_n = 1'b1;
    @(negedge clk_sys);
    chk("lut_write_en", 16'h0001, {15'h0000, lut_write_en});
    rd(ADDR_PWM_CFG, 8'h20);
    rd(ADDR_SPIN_CFG, 8'h3F);
    rd(ADDR_FREQ, 8'h17);
    end_sim();
  end
endmodule
